// ===== hw/dsq_pkg.sv
// Package for the delta-sigma conversion sequencer: register map, fields, timing.
`default_nettype none
package dsq_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses, one word per register).
  // ---------------------------------------------------------------
  localparam logic [7:0] DSQ_CTRL_OFS   = 8'h00; // Mode, resolution, start.
  localparam logic [7:0] DSQ_STATUS_OFS = 8'h04; // Sticky events, write one to clear.
  localparam logic [7:0] DSQ_MASK_OFS   = 8'h08; // Interrupt mask.
  localparam logic [7:0] DSQ_RESULT_OFS = 8'h0c; // Conversion result, read clears done.
  localparam logic [7:0] DSQ_DECIM_OFS  = 8'h10; // Decimation length per conversion.
  localparam logic [7:0] DSQ_STATE_OFS  = 8'h14; // Live sequencer state.

  // ---------------------------------------------------------------
  // Control register fields.
  // ---------------------------------------------------------------
  localparam int DSQ_CTRL_START_BIT = 0;  // Write one to start.
  localparam int DSQ_CTRL_MODE_LSB  = 1;  // Two bits of mode.
  localparam int DSQ_CTRL_RES_LSB   = 4;  // Five bits of resolution.
  localparam int DSQ_CTRL_ENA_BIT   = 9;  // Enable for free-running modes.
  localparam int DSQ_CTRL_INSW_BIT  = 10; // Write one: input selection changed.

  // Status bit positions.
  localparam int DSQ_ST_DONE_BIT    = 0;  // A result is ready.
  localparam int DSQ_ST_OVR_BIT     = 1;  // A result was overwritten unread.
  localparam int DSQ_ST_NUM         = 2;

  // Reset values.
  localparam logic [4:0]  DSQ_RES_RST   = 5'h10;   // 16 bits.
  localparam logic [15:0] DSQ_DECIM_RST = 16'h0040;

  // Resolution limits.
  localparam logic [4:0] DSQ_RES_MIN   = 5'h08;
  localparam logic [4:0] DSQ_RES_MAX   = 5'h14;
  localparam logic [4:0] DSQ_TURBO_MIN = 5'h11;

  // Priming: conversions discarded before the first valid one.
  localparam logic [1:0] DSQ_PRIME_CNT = 2'h3;

  // ---------------------------------------------------------------
  // Operating modes.
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DSQ_MODE_SINGLE,
    DSQ_MODE_CONT,
    DSQ_MODE_MULTI,
    DSQ_MODE_TURBO
  } dsq_mode_e;

endpackage : dsq_pkg

`default_nettype wire

// ===== hw/dsq_sequencer.sv
// Conversion sequencer and decimator for a delta-sigma converter.
//
// Contract
// - Four modes: single, continuous, multi, turbo.
// - Start by control bit or trigger input.
// - Completion sets status and holds done high.
// - Single: four conversions, result after fourth.
// - After single result read, back to standby.
// - Continuous: three primes, then every period.
// - Multi: reset and re-prime between samples.
// - Multi: next sample starts automatically.
// - Output invalid until fourth sample after switch.
// - Selectable resolution 8 to 20 bits.
// - Decimate serial bitstream into parallel results.
// - Results by polling, interrupt or DMA.
// - Turbo: wide resolutions prime once only.
`timescale 1ns/1ps
`default_nettype none

module dsq_sequencer
  import dsq_pkg::*;
#(
  parameter int RES_W = 20  // Widest result.
) (
  input  wire logic             clock_i,       // 10 MHz system clock.
  input  wire logic             arst_n_i,      // Asynchronous reset, active low.
  input  wire logic [7:0]       addr_i,        // Register byte address.
  input  wire logic [31:0]      wdata_i,       // Write data.
  input  wire logic             wr_i,          // Write strobe.
  input  wire logic             rd_i,          // Read strobe.
  output logic      [31:0]      rdata_o,       // Read data, one cycle later.
  input  wire logic             soc_i,         // Start-of-conversion trigger.
  input  wire logic             mod_bit_i,     // Modulator serial bitstream.
  input  wire logic             dma_ack_i,     // DMA read of the result.
  output logic                  eoc_o,         // Conversion done, held until read.
  output logic      [RES_W-1:0] result_o,      // Latest result.
  output logic                  mod_rst_o,     // Resets the modulator/decimator.
  output logic                  irq_o          // Level interrupt.
);

  // ---------------------------------------------------------------
  // Sequencer states.
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DSQ_ST_STANDBY,
    DSQ_ST_CONVERT,
    DSQ_ST_WAIT_READ
  } dsq_state_e;

  // Configuration registers.
  dsq_mode_e            mode_reg;       // Selected mode.
  logic [4:0]           res_reg;        // Resolution in bits.
  logic                 ena_reg;        // Free-run enable.
  logic [15:0]          decim_reg;      // Modulator bits per conversion.
  logic [DSQ_ST_NUM-1:0] status_reg;    // Sticky events.
  logic [DSQ_ST_NUM-1:0] mask_reg;      // Interrupt mask.

  // Sequencer and decimator state.
  dsq_state_e           state_reg;      // Current state.
  logic [15:0]          bit_cnt_reg;    // Bits into this conversion.
  logic [1:0]           prime_reg;      // Conversions still to discard.
  logic [RES_W+1:0]     acc_reg;        // Ones count of this conversion.
  logic [RES_W-1:0]     result_reg;     // Held result.
  logic                 eoc_reg;        // Done flag.
  logic [31:0]          rdata_reg;      // Read data register.

  // Decoded events.
  logic wr_ctrl;     // Write to control.
  logic start_sw;    // Software start bit.
  logic input_sw;    // Input selection changed.
  logic start_any;   // Any start request.
  logic res_read;    // Result read accepted.
  logic conv_end;    // Conversion period ends this cycle.
  logic deliver;     // A valid result is produced this cycle.
  logic wide_turbo;  // Turbo at 17 bits or more.

  // ---------------------------------------------------------------
  // Helper functions.
  // ---------------------------------------------------------------
  // Clamps a requested resolution into the supported range.
  function automatic logic [4:0] clamp_res(input logic [4:0] r);
    clamp_res = (r < DSQ_RES_MIN) ? DSQ_RES_MIN : ((r > DSQ_RES_MAX) ? DSQ_RES_MAX : r);
  endfunction

  // Scales the ones count to the configured width by shifting it down by RES_W minus the resolution.
  function automatic logic [RES_W-1:0] scale(input logic [RES_W+1:0] a, input logic [4:0] r);
    logic [RES_W+1:0] s;
    s = a >> (RES_W - int'(r));
    scale = s[RES_W-1:0];
  endfunction

  // ---------------------------------------------------------------
  // Event decode.
  // ---------------------------------------------------------------
  assign wr_ctrl    = wr_i && (addr_i == DSQ_CTRL_OFS);
  assign start_sw   = wr_ctrl && wdata_i[DSQ_CTRL_START_BIT];
  assign input_sw   = wr_ctrl && wdata_i[DSQ_CTRL_INSW_BIT];
  assign start_any  = start_sw || soc_i;
  assign res_read   = (rd_i && (addr_i == DSQ_RESULT_OFS)) || dma_ack_i;
  assign conv_end   = (state_reg == DSQ_ST_CONVERT) && (bit_cnt_reg == decim_reg - 16'h0001);
  assign deliver    = conv_end && (prime_reg == 2'h0);
  assign wide_turbo = (mode_reg == DSQ_MODE_TURBO) && (res_reg >= DSQ_TURBO_MIN);

  // ---------------------------------------------------------------
  // Configuration registers.
  // ---------------------------------------------------------------
  // Mode and resolution take effect as soon as they are written; changing them
  // mid-sequence is tolerated but the running result may be a mix.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_reg  <= DSQ_MODE_SINGLE;
      res_reg   <= DSQ_RES_RST;
      ena_reg   <= 1'b0;
      decim_reg <= DSQ_DECIM_RST;
    end else begin
      if (wr_ctrl) begin
        mode_reg <= dsq_mode_e'(wdata_i[DSQ_CTRL_MODE_LSB +: 2]);
        res_reg  <= clamp_res(wdata_i[DSQ_CTRL_RES_LSB +: 5]);
        ena_reg  <= wdata_i[DSQ_CTRL_ENA_BIT];
      end
      if (wr_i && (addr_i == DSQ_DECIM_OFS) && (wdata_i[15:0] != 16'h0000)) begin
        decim_reg <= wdata_i[15:0];
      end
    end
  end

  // Mask register.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_reg <= '0;
    end else if (wr_i && (addr_i == DSQ_MASK_OFS)) begin
      mask_reg <= wdata_i[DSQ_ST_NUM-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Sequencer state machine.
  // ---------------------------------------------------------------
  // Free-running modes stop at the end of the running conversion once the enable is dropped; single mode always
  // waits for the result to be read before it listens for triggers again.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= DSQ_ST_STANDBY;
    end else begin
      case (state_reg)
        DSQ_ST_STANDBY: begin
          if (start_any) begin
            state_reg <= DSQ_ST_CONVERT;
          end
        end
        DSQ_ST_CONVERT: begin
          if (deliver && (mode_reg == DSQ_MODE_SINGLE)) begin
            state_reg <= DSQ_ST_WAIT_READ;
          end else if (conv_end && (mode_reg != DSQ_MODE_SINGLE) && !ena_reg) begin
            state_reg <= DSQ_ST_STANDBY;
          end
        end
        DSQ_ST_WAIT_READ: begin
          if (res_read) begin
            state_reg <= DSQ_ST_STANDBY;
          end
        end
        default: state_reg <= DSQ_ST_STANDBY;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Conversion period counter.
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_cnt_reg <= 16'h0000;
    end else if ((state_reg != DSQ_ST_CONVERT) || conv_end) begin
      bit_cnt_reg <= 16'h0000;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Priming counter.
  // ---------------------------------------------------------------
  // Three conversions are discarded at every fresh start, after each result in
  // multi mode and narrow turbo, and after any input switch.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prime_reg <= DSQ_PRIME_CNT;
    end else if (input_sw) begin
      prime_reg <= DSQ_PRIME_CNT;
    end else if ((state_reg == DSQ_ST_STANDBY) && start_any) begin
      prime_reg <= DSQ_PRIME_CNT;
    end else if (conv_end) begin
      if (prime_reg != 2'h0) begin
        prime_reg <= prime_reg - 2'h1;
      end else if ((mode_reg == DSQ_MODE_MULTI) ||
                   ((mode_reg == DSQ_MODE_TURBO) && !wide_turbo)) begin
        prime_reg <= DSQ_PRIME_CNT;
      end
    end
  end

  // The decimator is held in reset outside conversions and pulsed after each result
  // in multi and both turbo modes; wide turbo only skips the re-priming.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mod_rst_o <= 1'b1;
    end else begin
      mod_rst_o <= (state_reg != DSQ_ST_CONVERT) ||
                   (deliver && (mode_reg != DSQ_MODE_CONT));
    end
  end

  // ---------------------------------------------------------------
  // Decimator: counts ones over each conversion period.
  // ---------------------------------------------------------------
  // A plain counting filter trades stopband rejection for tiny area; the
  // priming conversions still flush the analog side after a switch.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_reg <= '0;
    end else if ((state_reg != DSQ_ST_CONVERT) || conv_end) begin
      acc_reg <= '0;
    end else if (mod_bit_i) begin
      acc_reg <= acc_reg + (RES_W+2)'(1);
    end
  end

  // Result register updates on each valid conversion.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_reg <= '0;
    end else if (deliver) begin
      result_reg <= scale(acc_reg + (mod_bit_i ? (RES_W+2)'(1) : '0), res_reg);
    end
  end
  assign result_o = result_reg;

  // ---------------------------------------------------------------
  // Done flag: a new result wins over a read in the same cycle.
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      eoc_reg <= 1'b0;
    end else if (deliver) begin
      eoc_reg <= 1'b1;
    end else if (res_read) begin
      eoc_reg <= 1'b0;
    end
  end

  // The read clears done combinationally so the line drops in the read cycle.
  assign eoc_o = eoc_reg && !res_read;

  // ---------------------------------------------------------------
  // Sticky status and interrupt.
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_reg <= '0;
    end else begin
      for (int i = 0; i < DSQ_ST_NUM; i++) begin
        if (wr_i && (addr_i == DSQ_STATUS_OFS) && wdata_i[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
      if (res_read) begin
        status_reg[DSQ_ST_DONE_BIT] <= 1'b0;
      end
      if (deliver) begin
        status_reg[DSQ_ST_DONE_BIT] <= 1'b1;
        if (eoc_reg && !res_read) begin
          status_reg[DSQ_ST_OVR_BIT] <= 1'b1;
        end
      end
    end
  end

  assign irq_o = |(status_reg & mask_reg);

  // ---------------------------------------------------------------
  // Read data path.
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        DSQ_CTRL_OFS:   rdata_reg <= 32'(ena_reg) << DSQ_CTRL_ENA_BIT |
                                     32'(res_reg) << DSQ_CTRL_RES_LSB |
                                     32'(mode_reg) << DSQ_CTRL_MODE_LSB;
        DSQ_STATUS_OFS: rdata_reg <= 32'(status_reg);
        DSQ_MASK_OFS:   rdata_reg <= 32'(mask_reg);
        DSQ_RESULT_OFS: rdata_reg <= 32'(result_reg);
        DSQ_DECIM_OFS:  rdata_reg <= 32'(decim_reg);
        DSQ_STATE_OFS:  rdata_reg <= 32'(prime_reg) << 2 | 32'(state_reg);
        default:        rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end
  assign rdata_o = rdata_reg;

endmodule : dsq_sequencer

`default_nettype wire

// ===== sim/dsq_sequencer_asserts.sv
// Port-level assertions for the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
module dsq_sequencer_chk
  import dsq_pkg::*;
#(
  parameter int RES_W = 20  // Widest result.
) (
  input wire logic             clock_i,    // System clock.
  input wire logic             arst_n_i,   // Asynchronous reset, active low.
  input wire logic [7:0]       addr_i,     // Register address.
  input wire logic [31:0]      wdata_i,    // Write data.
  input wire logic             wr_i,       // Write strobe.
  input wire logic             rd_i,       // Read strobe.
  input wire logic             soc_i,      // Trigger.
  input wire logic             dma_ack_i,  // DMA collection.
  input wire logic             eoc_o,      // Done level.
  input wire logic [RES_W-1:0] result_o,   // Result.
  input wire logic             mod_rst_o   // Decimator reset.
);
  // ----------------------------------------------------------------
  // Copies of what software last wrote; the checker sees no internals.
  // ----------------------------------------------------------------
  logic [1:0]  mode_reg;   // Operating mode.
  logic        ena_reg;    // Free-running enable.
  logic [15:0] decim_reg;  // Conversion length; a zero write is ignored.
  logic        res_rd;     // A result read is present this cycle.
  assign res_rd = dma_ack_i || (rd_i && addr_i == DSQ_RESULT_OFS);
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_reg  <= 2'h0;
      ena_reg   <= 1'b0;
      decim_reg <= DSQ_DECIM_RST;
    end else if (wr_i && addr_i == DSQ_CTRL_OFS) begin
      mode_reg <= wdata_i[DSQ_CTRL_MODE_LSB +: 2];
      ena_reg  <= wdata_i[DSQ_CTRL_ENA_BIT];
    end else if (wr_i && addr_i == DSQ_DECIM_OFS && wdata_i[15:0] != 16'h0) begin
      decim_reg <= wdata_i[15:0];
    end
  end
  // ----------------------------------------------------------------
  // Properties.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // A trigger in single mode from standby, with the short length the bench uses.
  sequence s_single_trig;
    soc_i && mod_rst_o && !eoc_o && !res_rd && mode_reg == DSQ_MODE_SINGLE && decim_reg == 16'h4;
  endsequence
  // Four conversions of four clocks with no result shown.
  sequence s_four_quiet;
    !eoc_o [*8] ##1 !eoc_o [*8];
  endsequence
  property p_single_lat; s_single_trig |=> s_four_quiet ##1 eoc_o; endproperty
  property p_done_hold; eoc_o |=> eoc_o || res_rd; endproperty
  property p_read_clears; res_rd |-> !eoc_o; endproperty
  property p_res_from_conv; $rose(eoc_o) |-> !$past(mod_rst_o); endproperty
  property p_result_held; eoc_o && mode_reg == DSQ_MODE_SINGLE |=> $stable(result_o); endproperty
  property p_stay_standby; res_rd && $past(eoc_o) && mode_reg == DSQ_MODE_SINGLE |=> mod_rst_o && !eoc_o; endproperty
  property p_cont_flow; $rose(eoc_o) && ena_reg && mode_reg == DSQ_MODE_CONT |-> !mod_rst_o [*2]; endproperty
  property p_multi_reprime;
    $rose(eoc_o) && ena_reg && mode_reg == DSQ_MODE_MULTI |-> ##[0:1] mod_rst_o ##[1:2] !mod_rst_o;
  endproperty
  a_single_lat: assert property (p_single_lat) else $error("single result not after four conversions");
  a_done_hold: assert property (p_done_hold) else $error("done dropped without a read");
  a_read_clears: assert property (p_read_clears) else $error("done high during a result read");
  a_res_from_conv: assert property (p_res_from_conv) else $error("result without conversion");
  a_result_held: assert property (p_result_held) else $error("result changed while waiting");
  a_stay_standby: assert property (p_stay_standby) else $error("no standby after read");
  a_cont_flow: assert property (p_cont_flow) else $error("continuous mode re-primed");
  a_multi_reprime: assert property (p_multi_reprime) else $error("multi mode not re-primed");
endmodule // dsq_sequencer_chk

bind dsq_sequencer dsq_sequencer_chk #(.RES_W(RES_W)) u_chk (.clock_i, .arst_n_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .soc_i, .dma_ack_i, .eoc_o, .result_o, .mod_rst_o);
`default_nettype wire

// ===== sim/dsq_dma_model.sv
// Model of the DMA controller that collects conversion results.
`timescale 1ns/1ps
`default_nettype none
module dsq_dma_model
  import dsq_pkg::*;
#(
  parameter int RES_W = 20  // Result width.
) (
  input  wire logic             clock_i,   // System clock.
  input  wire logic             arst_n_i,  // Asynchronous reset, active low.
  input  wire logic             enable_i,  // Collect results.
  input  wire logic [3:0]       delay_i,   // Cycles of hesitation before a read.
  input  wire logic             eoc_i,     // Done level from the sequencer.
  input  wire logic [RES_W-1:0] result_i,  // Result from the sequencer.
  output logic                  ack_o,     // One-cycle read pulse.
  output logic      [RES_W-1:0] data_o,    // Last result collected.
  output logic      [15:0]      count_o    // Results collected.
);
  logic [3:0] wait_reg;  // Hesitation so far.
  // ----------------------------------------------------------------
  // Read on the done level after the delay; a slow reader may lose results.
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_o    <= 1'b0;
      wait_reg <= 4'h0;
    end else begin
      ack_o <= 1'b0;
      if (enable_i && eoc_i && !ack_o) begin
        if (wait_reg == delay_i) begin
          ack_o    <= 1'b1;
          wait_reg <= 4'h0;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end
  // The result is taken at the edge that ends the read pulse.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_o  <= '0;
      count_o <= 16'h0;
    end else if (ack_o) begin
      data_o  <= result_i;
      count_o <= count_o + 16'h1;
    end
  end
endmodule // dsq_dma_model
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking testbench for the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dsq_pkg::*;
;
  localparam int DEC = 4;  // Short conversion keeps the run brief.
  // Mode table: continuous, multi, narrow turbo, wide turbo.
  localparam logic [31:0] MCTRL [4] = '{32'h142, 32'h144, 32'h106, 32'h146};
  localparam int          GAP   [4] = '{DEC, 4 * DEC, 4 * DEC, DEC};
  localparam logic [3:0]  DLY   [4] = '{4'h0, 4'h2, 4'h2, 4'h0};
  logic        clock_i, arst_n_i, wr_i, rd_i, soc_i, mod_bit_i, eoc_o, mod_rst_o, irq_o, dma_ack, dma_en;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, rv;
  logic [3:0]  dma_dly;
  logic [19:0] result_o, dma_data;
  int          miscompares = 0;
  int          checks_done = 0;
  int          n;
  dsq_sequencer #(.RES_W(20)) uut (.clock_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .soc_i,
    .mod_bit_i, .dma_ack_i(dma_ack), .eoc_o, .result_o, .mod_rst_o, .irq_o);
  dsq_dma_model u_dma (.clock_i, .arst_n_i, .enable_i(dma_en), .delay_i(dma_dly), .eoc_i(eoc_o),
    .result_i(result_o), .ack_o(dma_ack), .data_o(dma_data), .count_o());
  // ----------------------------------------------------------------
  // Clock and an alternating bitstream, so any four bits hold two ones.
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  always @(posedge clock_i) mod_bit_i <= ~mod_bit_i;
  // ----------------------------------------------------------------
  // Bus tasks and checks.
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic trig;
    @(posedge clock_i);
    soc_i <= 1'b1;
    @(posedge clock_i);
    soc_i <= 1'b0;
  endtask
  // Bounded wait for done (sel 0) or a DMA read (sel 1); the cycle count lands in n.
  task automatic wait_ev(input bit sel);
    n = 0;
    do begin
      @(posedge clock_i);
      #1 n++;
    end while ((sel ? dma_ack : eoc_o) !== 1'b1 && n < 300);
    if (n >= 300) begin
      $display("ERROR wait expected event seen timeout");
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    {arst_n_i, wr_i, rd_i, soc_i, mod_bit_i, dma_en, addr_i, wdata_i, dma_dly} = '0;
    repeat (2) @(posedge clock_i);
    arst_n_i <= 1'b1;
    chk("reset decim hold", 1, mod_rst_o);
    chk("reset outputs", 0, {eoc_o, irq_o, result_o});
    chk("reset rdata", 0, rdata_o);
    rd(DSQ_CTRL_OFS, rv);
    chk("ctrl reset", 32'(DSQ_RES_RST) << 4, rv);
    rd(DSQ_DECIM_OFS, rv);
    chk("decim reset", 32'(DSQ_DECIM_RST), rv);
    rd(8'h18, rv);
    chk("unmapped", 0, rv);
    wr(DSQ_CTRL_OFS, 32'h1f0);
    rd(DSQ_CTRL_OFS, rv);
    chk("res clamp", 32'h140, rv);
    wr(DSQ_DECIM_OFS, DEC);
    wr(DSQ_MASK_OFS, 1);
    $display("test registers done");
    // Single sample by trigger; a second trigger mid-sequence must not restart it.
    trig();
    repeat (3) @(posedge clock_i);
    trig();
    wait_ev(0);
    chk("single latency", 4 * DEC - 5, n);
    // Waiting for the read with no primes left: state code two, primes zero.
    rd(DSQ_STATE_OFS, rv);
    chk("state wait read", 2, rv);
    chk("irq", 1, irq_o);
    wr(DSQ_MASK_OFS, 0);
    chk("irq masked", 0, irq_o);
    wr(DSQ_MASK_OFS, 1);
    rd(DSQ_STATUS_OFS, rv);
    chk("status done", 1, rv);
    rd(DSQ_RESULT_OFS, rv);
    chk("result", 2, rv);
    chk("done cleared", 0, eoc_o);
    wr(DSQ_STATUS_OFS, 3);
    chk("irq cleared", 0, irq_o);
    repeat (20) @(posedge clock_i);
    #1 chk("standby", 1, mod_rst_o & ~eoc_o);
    // Single sample by the start bit at 19 bits.
    wr(DSQ_CTRL_OFS, 32'h131);
    wait_ev(0);
    chk("start latency", 4 * DEC, n);
    rd(DSQ_RESULT_OFS, rv);
    chk("result narrow", 1, rv);
    $display("test single done");
    // Free-running modes collected by DMA; the input switches only in wide turbo mode.
    dma_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      dma_dly <= DLY[i];
      wr(DSQ_CTRL_OFS, MCTRL[i] | 32'h201);
      wait_ev(1);
      chk("first", 4 * DEC + 1 + DLY[i], n);
      wait_ev(1);
      chk("period", GAP[i], n);
      if (i == 3) begin
        wr(DSQ_CTRL_OFS, MCTRL[i] | 32'h600);
        wait_ev(1);
        chk("reprimed", 3 * DEC + 2, n);
      end
      wr(DSQ_CTRL_OFS, MCTRL[i]);
      repeat (40) @(posedge clock_i);
      #1 chk("drained", 1, mod_rst_o & ~eoc_o);
      chk("dma data", 32'(2 >> (20 - MCTRL[i][8:4])), 32'(dma_data));
      $display("test mode %0d done", i);
    end
    // Continuous with nobody collecting: the second result overruns the first.
    dma_en <= 1'b0;
    wr(DSQ_CTRL_OFS, MCTRL[0] | 32'h201);
    repeat (5 * DEC + 1) @(posedge clock_i);
    wr(DSQ_CTRL_OFS, MCTRL[0]);
    rd(DSQ_STATUS_OFS, rv);
    chk("status overrun", 3, rv);
    rd(DSQ_RESULT_OFS, rv);
    wr(DSQ_STATUS_OFS, 3);
    chk("overrun cleared", 0, {eoc_o, irq_o});
    $display("test overrun done");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
